// File: apd_consts.svh
// timing counts, field positions and clip level codes for the protection/diagnostic block
// assumes a 200 MHz system clock
`ifndef APD_CONSTS_SVH
`define APD_CONSTS_SVH
`define APD_CLK_MHZ 200
`define APD_DEBOUNCE_US 2
`define APD_DEBOUNCE_CYC (`APD_DEBOUNCE_US * `APD_CLK_MHZ)
`define APD_FMUTE_US 100
`define APD_FMUTE_CYC (`APD_FMUTE_US * `APD_CLK_MHZ)
`define APD_AC_TRIG_COUNT 3
// instruction byte one
`define APD_IB1_START 0
`define APD_IB1_DC_EN 1
`define APD_IB1_AC_EN 2
`define APD_IB1_CLIP_CH2 3
`define APD_IB1_CLIP_CH4 4
`define APD_IB1_CLIP_CH1 5
`define APD_IB1_CLIP_CH3 6
// instruction byte two
`define APD_IB2_LOAD_OFF 4
`define APD_IB2_TEMP_OFF 5
`define APD_IB2_CLIP_LO 6
// instruction byte three
`define APD_IB3_WARN_SEL 4
// status bytes
`define APD_DB2_POR 7
`define APD_DBX_OFFSET 2
`define APD_DBX_LOAD_LO 4
`define APD_DBX_LOAD_HI 5
`define APD_DBX_OVERTEMP 6
`define APD_DBX_SHORT 0
`define APD_DBX_MISSING 1
`define APD_DB2_LOW_BAT 0
`define APD_DB2_HIGH_BAT 1
`define APD_DB2_WARN 2
`define APD_DB2_OFF_TEMP 3
`define APD_CLIP_2PCT 2'h0
`define APD_CLIP_OFF 2'h3
`endif

// File: apd_pkg.sv
// types for the protection/diagnostic block
package apd_pkg;
  typedef enum logic [4:0] {
    APD_OFF = 5'h01,
    APD_WAIT_START = 5'h02,
    APD_STARTUP = 5'h04,
    APD_RUN = 5'h08,
    APD_HEADROOM = 5'h10
  } apd_state_t;
  typedef logic [7:0] apd_byte_t;
endpackage

// File: apd_sync_filter.sv
// two-flop synchroniser plus a stable-count debounce, one per bit
// assumes inputs are asynchronous analog comparator levels
`timescale 1ns/100ps
module apd_sync_filter #(
  parameter int WIDTH = 8,
  parameter int STABLE = 400
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_sync_n,
  // levels
  input wire logic [WIDTH-1:0] raw,
  output logic [WIDTH-1:0] clean
);
  localparam int CW = $clog2(STABLE + 1);
  initial begin
    if (WIDTH < 1 || STABLE < 1) $error("apd_sync_filter: bad parameters");
  end
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] sync;
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      meta <= '0;
      sync <= '0;
    end else begin
      meta <= raw;
      sync <= meta;
    end
  end
  // a bit must hold for STABLE cycles before the output follows it
  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [CW-1:0] cnt;
    wire differs = sync[i] != clean[i];
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        cnt <= '0;
        clean[i] <= 1'b0;
      end else if (!differs) begin
        cnt <= '0;
      end else if (cnt == CW'(STABLE - 1)) begin
        cnt <= '0;
        clean[i] <= sync[i];
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end
endmodule // apd_sync_filter

// File: apd_protect.sv
// protection and diagnostic control of a four-channel bridge amplifier
// assumes analog comparators arrive asynchronously; the bus decoder on clk_sys supplies instruction bytes
`timescale 1ns/100ps
`include "apd_consts.svh"
module apd_protect
  import apd_pkg::*;
#(
  parameter int DEBOUNCE_CYC = `APD_DEBOUNCE_CYC,
  parameter int FMUTE_CYC = `APD_FMUTE_CYC,
  parameter int AC_TRIGS = `APD_AC_TRIG_COUNT
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // mode and instruction bytes from bus decoder
  input wire logic bus_mode,
  input wire apd_pkg::apd_byte_t instruction_byte_one,
  input wire apd_pkg::apd_byte_t instruction_byte_two,
  input wire apd_pkg::apd_byte_t instruction_byte_three,
  // host read strobes (one cycle, clk_sys domain)
  input wire logic rd_status,
  input wire logic rd_offset,
  // pins and analog comparators (asynchronous)
  input wire logic standby_pin_in,
  input wire logic low_headroom,
  input wire logic supply_above_mute,
  input wire logic supply_below_reset,
  input wire logic supply_low_bat,
  input wire logic supply_over,
  input wire logic temp_warn_lo,
  input wire logic temp_warn_hi,
  input wire logic temp_off,
  input wire logic ripple_reject_empty,
  input wire logic [3:0] clip_det,
  input wire logic [3:0] short_det,
  input wire logic [3:0] missing_det,
  input wire logic [3:0] offset_in_window,
  input wire logic [3:0] dc_line_driver,
  input wire logic [3:0] dc_open,
  input wire logic [3:0] ac_peak,
  // amplifier controls
  output logic fast_mute,
  output logic discharge_nodes,
  output logic amp_enable,
  output logic outputs_hiz,
  output logic gain_reduce,
  output logic dc_detect_run,
  output logic ac_detect_run,
  output logic warn_level_sel,
  output logic [1:0] clip_level,
  // open-drain indicator pins, oe low means pulled low
  output logic fault_indicator_pin_out,
  output logic fault_indicator_pin_oe_n,
  output logic standby_pin_out,
  output logic standby_pin_oe_n,
  // status bytes
  output apd_pkg::apd_byte_t status_byte_two,
  output apd_pkg::apd_byte_t channel_status_byte [4]
);
  if (AC_TRIGS < 1 || AC_TRIGS > 7) begin : g_bad_trigs
    $error("apd_protect: AC_TRIGS out of range");
  end
  if (FMUTE_CYC < 1) begin : g_bad_mute
    $error("apd_protect: FMUTE_CYC too small");
  end
  if (DEBOUNCE_CYC < 1) begin : g_bad_debounce
    $error("apd_protect: DEBOUNCE_CYC too small");
  end

  logic rst_meta;
  logic rst_sync_n;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync_n <= rst_meta;
    end
  end

  localparam int NIN = 38;
  logic [NIN-1:0] clean;
  apd_sync_filter #(.WIDTH(NIN), .STABLE(DEBOUNCE_CYC)) u_filt (
    .clk_sys(clk_sys),
    .rst_sync_n(rst_sync_n),
    .raw({ac_peak, dc_open, dc_line_driver, offset_in_window, missing_det, short_det, clip_det,
          ripple_reject_empty, temp_off, temp_warn_hi, temp_warn_lo, supply_over, supply_low_bat,
          supply_below_reset, supply_above_mute, low_headroom, standby_pin_in}),
    .clean(clean)
  );
  wire stb = clean[0];
  wire hr_low = clean[1];
  wire above_mute = clean[2];
  wire below_reset = clean[3];
  wire low_bat = clean[4];
  wire over_v = clean[5];
  wire t_lo = clean[6];
  wire t_hi = clean[7];
  wire t_off = clean[8];
  wire rr_empty = clean[9];
  wire [3:0] clip = clean[13:10];
  wire [3:0] shrt = clean[17:14];
  wire [3:0] miss = clean[21:18];
  wire [3:0] in_win = clean[25:22];
  wire [3:0] ld_line = clean[29:26];
  wire [3:0] ld_open = clean[33:30];
  wire [3:0] peak = clean[37:34];

  // legacy mode ignores the start bit and treats every other bit as zero
  wire start_req = bus_mode ? instruction_byte_one[`APD_IB1_START] : 1'b1;
  wire dc_en = bus_mode & instruction_byte_one[`APD_IB1_DC_EN];
  wire ac_en = bus_mode & instruction_byte_one[`APD_IB1_AC_EN];
  wire [3:0] clip_to_stb = bus_mode ? {instruction_byte_one[`APD_IB1_CLIP_CH4],
                                       instruction_byte_one[`APD_IB1_CLIP_CH3],
                                       instruction_byte_one[`APD_IB1_CLIP_CH2],
                                       instruction_byte_one[`APD_IB1_CLIP_CH1]} : 4'h0;
  wire temp_on_fault = !bus_mode || !instruction_byte_two[`APD_IB2_TEMP_OFF];
  wire load_on_fault = !bus_mode || !instruction_byte_two[`APD_IB2_LOAD_OFF];
  wire [1:0] clip_sel = bus_mode ? instruction_byte_two[`APD_IB2_CLIP_LO +: 2] : `APD_CLIP_2PCT;
  wire clip_enabled = clip_sel != `APD_CLIP_OFF;
  wire warn_sel = bus_mode & instruction_byte_three[`APD_IB3_WARN_SEL];
  wire t_warn = warn_sel ? t_hi : t_lo;
  wire por_event = bus_mode & below_reset;

  apd_state_t state;
  apd_state_t next_state;
  logic por_flag;
  logic [$clog2(FMUTE_CYC+1)-1:0] mute_cnt;
  wire mute_done = mute_cnt == '0;

  always_comb begin
    next_state = state;
    case (state)
      APD_OFF: if (stb) next_state = APD_WAIT_START;
      APD_WAIT_START: if (!stb) next_state = APD_OFF;
        else if (start_req && !por_flag && above_mute) next_state = APD_STARTUP;
      APD_STARTUP: if (!stb) next_state = APD_OFF;
        else if (hr_low) next_state = APD_HEADROOM;
        else if (rr_empty == 1'b0 && !below_reset) next_state = APD_RUN;
      APD_RUN: if (!stb) next_state = APD_OFF;
        else if (hr_low) next_state = APD_HEADROOM;
      APD_HEADROOM: if (mute_done && rr_empty) begin
          // headroom recovery parks the amplifier in APD_WAIT_START once the mute count ends and rr_empty is set
          next_state = APD_WAIT_START;
        end
      default: next_state = APD_OFF;
    endcase
    if (por_event || t_off) next_state = stb ? APD_WAIT_START : APD_OFF;
  end

  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      state <= APD_OFF;
      mute_cnt <= '0;
    end else begin
      state <= next_state;
      if (next_state == APD_HEADROOM && state != APD_HEADROOM) begin
        mute_cnt <= ($bits(mute_cnt))'(FMUTE_CYC);
      end else if (!mute_done) begin
        mute_cnt <= mute_cnt - 1'b1;
      end
    end
  end

  // power-on flag: standby rising in bus mode is a power-on reset too
  wire por_set = por_event | (bus_mode & (state == APD_OFF) & stb);
  // in bus mode only a fresh start command clears it; a start bit left set across a supply drop must not restart
  logic start_q;
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_req;
    end
  end
  wire start_rise = start_req & !start_q;
  // legacy mode has no power-on flag to wait on
  wire por_clr = (state == APD_WAIT_START) & (!bus_mode | start_rise);

  // the set wins over the start-bit clear
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      por_flag <= 1'b0;
    end else if (por_set) begin
      por_flag <= 1'b1;
    end else if (por_clr) begin
      por_flag <= 1'b0;
    end
  end
  wire por_pending = por_flag;

  // AC peak counters, active only after start-up completed
  logic [2:0] ac_cnt [4];
  logic [3:0] peak_q;
  logic [3:0] ac_hit;
  assign ac_detect_run = ac_en & (state == APD_RUN);
  wire [3:0] peak_rise = peak & ~peak_q;
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      peak_q <= 4'h0;
    end else begin
      peak_q <= peak;
    end
  end
  for (genvar c = 0; c < 4; c++) begin : g_ac
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        ac_cnt[c] <= 3'h0;
        ac_hit[c] <= 1'b0;
      end else if (!ac_detect_run) begin
        ac_cnt[c] <= 3'h0;
      end else if (peak_rise[c]) begin
        if (ac_cnt[c] == 3'(AC_TRIGS - 1)) ac_hit[c] <= 1'b1;
        else ac_cnt[c] <= ac_cnt[c] + 3'h1;
      end else if (rd_status && !(ac_hit[c] && ac_cnt[c] == 3'(AC_TRIGS - 1))) begin
        ac_hit[c] <= 1'b0;
      end
    end
  end

  // DC load result stored during start-up, kept while AC detection runs
  logic [1:0] dc_res [4];
  assign dc_detect_run = dc_en & (state == APD_STARTUP);
  // latched channel faults and offset latches
  logic [3:0] short_lat;
  logic [3:0] miss_lat;
  logic [3:0] off_lat;
  logic [3:0] off_block;
  for (genvar c = 0; c < 4; c++) begin : g_ch
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
        dc_res[c] <= 2'h0;
        short_lat[c] <= 1'b0;
        miss_lat[c] <= 1'b0;
        off_lat[c] <= 1'b0;
        off_block[c] <= 1'b0;
      end else begin
        if (dc_detect_run) dc_res[c] <= ld_open[c] ? 2'h3 : (ld_line[c] ? 2'h2 : 2'h0);
        short_lat[c] <= shrt[c] | (short_lat[c] & !rd_status);
        miss_lat[c] <= miss[c] | (miss_lat[c] & !rd_status);
        if (in_win[c]) begin
          off_lat[c] <= 1'b0;
          off_block[c] <= 1'b1;
        end else if (rd_offset) begin
          off_lat[c] <= !off_block[c];
          off_block[c] <= 1'b0;
        end
      end
    end
    // D4 carries the AC result while AC detection is on, the stored DC bit otherwise
    wire d4 = ac_en ? ac_hit[c] : dc_res[c][0];
    assign channel_status_byte[c] = {1'b0, t_warn, dc_res[c][1], d4, 1'b0, off_lat[c],
                                     miss_lat[c], short_lat[c]};
  end

  // supply and thermal latches
  logic low_bat_lat;
  logic high_bat_lat;
  logic warn_lat;
  logic toff_lat;
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      low_bat_lat <= 1'b0;
      high_bat_lat <= 1'b0;
      warn_lat <= 1'b0;
      toff_lat <= 1'b0;
    end else begin
      low_bat_lat <= low_bat | (low_bat_lat & !rd_status);
      high_bat_lat <= over_v | (high_bat_lat & !rd_status);
      warn_lat <= t_warn | (warn_lat & !rd_status);
      toff_lat <= t_off | (toff_lat & !rd_status);
    end
  end
  assign status_byte_two = {por_flag, 3'h0, toff_lat, warn_lat, high_bat_lat, low_bat_lat};

  // fault pin follows live conditions, except the power-on flag latched in bus mode, so it releases as soon as a failure clears
  wire fixed_src = (bus_mode & por_pending) | low_bat | over_v;
  wire load_src = load_on_fault & |(shrt | miss);
  wire temp_src = temp_on_fault & t_warn;
  wire clip_fault_indicator_pin = clip_enabled & |(clip & ~clip_to_stb);
  wire clip_stb = clip_enabled & |(clip & clip_to_stb);
  wire fault_low = fixed_src | load_src | temp_src | clip_fault_indicator_pin;

  wire in_amp_state = (state == APD_STARTUP) || (state == APD_RUN);
  always_ff @(posedge clk_sys or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      fault_indicator_pin_oe_n <= 1'b1;
      standby_pin_oe_n <= 1'b1;
      fast_mute <= 1'b1;
      discharge_nodes <= 1'b0;
      amp_enable <= 1'b0;
      outputs_hiz <= 1'b1;
      gain_reduce <= 1'b0;
      warn_level_sel <= 1'b0;
      clip_level <= 2'h0;
    end else begin
      fault_indicator_pin_oe_n <= !fault_low;
      standby_pin_oe_n <= !clip_stb;
      fast_mute <= !stb || (state != APD_RUN);
      discharge_nodes <= (state == APD_HEADROOM) && mute_done;
      amp_enable <= in_amp_state && !t_off && above_mute;
      outputs_hiz <= over_v;
      gain_reduce <= t_warn;
      warn_level_sel <= warn_sel;
      clip_level <= clip_sel;
    end
  end
  assign fault_indicator_pin_out = 1'b0;
  assign standby_pin_out = 1'b0;
endmodule // apd_protect

// File: apd_protect_properties.sv
// concurrent checks on the ports of apd_protect
// assumes the bench filter setting keeps every port latency under eight cycles
`timescale 1ns/100ps
module apd_protect_checker
  import apd_pkg::*;
#(
  parameter int DEBOUNCE_CYC = 2,
  parameter int FMUTE_CYC = 4,
  parameter int AC_TRIGS = 3
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // stimulus side
  input wire logic bus_mode,
  input wire apd_pkg::apd_byte_t instruction_byte_one,
  input wire apd_pkg::apd_byte_t instruction_byte_two,
  input wire apd_pkg::apd_byte_t instruction_byte_three,
  input wire logic standby_pin_in,
  input wire logic supply_below_reset,
  input wire logic supply_low_bat,
  input wire logic supply_over,
  input wire logic temp_warn_lo,
  input wire logic temp_warn_hi,
  input wire logic temp_off,
  input wire logic [3:0] clip_det,
  input wire logic [3:0] short_det,
  input wire logic [3:0] missing_det,
  input wire logic [3:0] offset_in_window,
  input wire logic [3:0] ac_peak,
  // responses
  input wire logic fast_mute,
  input wire logic amp_enable,
  input wire logic outputs_hiz,
  input wire logic dc_detect_run,
  input wire logic ac_detect_run,
  input wire logic warn_level_sel,
  input wire logic [1:0] clip_level,
  input wire logic fault_indicator_pin_oe_n,
  input wire apd_pkg::apd_byte_t status_byte_two,
  input wire apd_pkg::apd_byte_t channel_status_byte [4]
);
  logic [5:0] up;
  logic [3:0] pk_cnt;
  logic pk_q;
  // the design's own reset copy and filter lag rst_n, so no check but a_acrun is judged before that
  wire ready = (up > 6'(DEBOUNCE_CYC + FMUTE_CYC + 4));
  wire quiet = !bus_mode && !supply_low_bat && !supply_over && !temp_warn_lo && !temp_warn_hi && !temp_off
    && ~|{clip_det, short_det, missing_det};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      up <= '0;
      pk_cnt <= '0;
      pk_q <= 1'b0;
    end else begin
      up <= ready ? up : up + 6'h01;
      pk_q <= ac_peak[0];
      pk_cnt <= !ac_detect_run ? 4'h0 : pk_cnt + 4'((ac_peak[0] && !pk_q && pk_cnt != 4'hf) ? 1 : 0);
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_hiz; (ready && supply_over) [*8] |=> outputs_hiz; endproperty
  a_hiz: assert property (p_hiz) else $error("outputs not high impedance on overvoltage");
  property p_bat; (ready && supply_low_bat) [*8] |=> !fault_indicator_pin_oe_n; endproperty
  a_bat: assert property (p_bat) else $error("low battery not on fault pin");
  property p_release; (ready && quiet) [*8] |=> fault_indicator_pin_oe_n; endproperty
  a_release: assert property (p_release) else $error("fault pin held without a failure");
  property p_stb_mute; (ready && !standby_pin_in) [*8] |=> fast_mute; endproperty
  a_stb_mute: assert property (p_stb_mute) else $error("standby low without fast mute");
  property p_por; (ready && bus_mode && status_byte_two[7]) [*3] |-> !fault_indicator_pin_oe_n; endproperty
  a_por: assert property (p_por) else $error("power-on flag set but fault pin released");
  property p_start;
    ready && bus_mode && $rose(instruction_byte_one[0]) && standby_pin_in && !supply_below_reset
      |-> ##[1:4] !status_byte_two[7];
  endproperty
  a_start: assert property (p_start) else $error("start bit did not clear power-on flag");
  property p_acrun; ac_detect_run |-> !dc_detect_run; endproperty
  a_acrun: assert property (p_acrun) else $error("ac and dc detection overlap");
  property p_accnt; ready && instruction_byte_one[2] && $rose(channel_status_byte[0][4]) |-> pk_cnt >= 4'(AC_TRIGS);
  endproperty
  a_accnt: assert property (p_accnt) else $error("ac load bit set before three peaks");
  property p_toff; (ready && temp_off) [*8] |=> !amp_enable; endproperty
  a_toff: assert property (p_toff) else $error("amplifier on above off temperature");
  property p_offset; (ready && offset_in_window[0]) [*8] |=> !channel_status_byte[0][2]; endproperty
  a_offset: assert property (p_offset) else $error("offset latch set inside window");
  property p_warn;
    (ready && $stable({bus_mode, instruction_byte_three[4]})) [*4] |-> warn_level_sel == (bus_mode && instruction_byte_three[4]);
  endproperty
  a_warn: assert property (p_warn) else $error("warning level select wrong");
  property p_clip;
    (ready && $stable({bus_mode, instruction_byte_two[7:6]})) [*4]
      |-> clip_level == (bus_mode ? instruction_byte_two[7:6] : 2'h0);
  endproperty
  a_clip: assert property (p_clip) else $error("clip level field wrong");
endmodule // apd_protect_checker

// File: apd_host_model.sv
// host side: instruction bytes and one-cycle read strobes
// assumes the bench calls its tasks from its own main sequence
`timescale 1ns/100ps
module apd_host_model
  import apd_pkg::*;
(
  // clock
  input wire logic clk_sys,
  // instruction bytes and read strobes
  output apd_pkg::apd_byte_t ib1,
  output apd_pkg::apd_byte_t ib2,
  output apd_pkg::apd_byte_t ib3,
  output logic rd_status,
  output logic rd_offset
);
  // all instruction bits read zero after power-on
  initial begin
    ib1 = 8'h00;
    ib2 = 8'h00;
    ib3 = 8'h00;
    rd_status = 1'b0;
    rd_offset = 1'b0;
  end
  // gain in dB from the load bits: 16 for the line-driver code 2'h2, 26 otherwise
  function automatic int gain_db(input logic [1:0] load);
    return (load == 2'h2) ? 16 : 26;
  endfunction
  task automatic write_ib(input apd_byte_t b1, input apd_byte_t b2, input apd_byte_t b3);
    @(negedge clk_sys);
    ib1 = b1;
    ib2 = b2;
    ib3 = b3;
  endtask
  task automatic read_pulse(input logic offs);
    @(negedge clk_sys);
    rd_offset = offs;
    rd_status = !offs;
    @(negedge clk_sys);
    rd_offset = 1'b0;
    rd_status = 1'b0;
  endtask
endmodule // apd_host_model

// File: amp_protection_diagnostics_tb.sv
// self-checking bench for apd_protect driven by a host model
// assumes shortened filter and mute counts; inputs change on the falling edge
`timescale 1ns/100ps
`include "apd_consts.svh"
module amp_protection_diagnostics_tb;
  import apd_pkg::*;
  logic clk_sys, rst_n, bus_mode, stb_drive, lo_hr, above_mute, below_rst, low_bat, over, twl, twh, toff, rre;
  logic rd_status, rd_offset, fmute, dis, amp_en, hiz, gred, dcrun, acrun, wsel, fo_oe_n, so_oe_n, dis_seen;
  logic [3:0] clip, shrt, miss, win, dc_ld, dc_op, peak;
  logic [1:0] clvl;
  apd_byte_t ib1, ib2, ib3, sb2;
  apd_byte_t csb [4];
  int err_total, checks, seed, c;
  // open-drain standby line: the design pulls it low when its enable is low
  wire stb_wire = stb_drive & so_oe_n;
  apd_host_model u_host (.clk_sys(clk_sys), .ib1(ib1), .ib2(ib2), .ib3(ib3), .rd_status(rd_status), .rd_offset(rd_offset));
  apd_protect #(.DEBOUNCE_CYC(2), .FMUTE_CYC(4), .AC_TRIGS(3)) u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .bus_mode(bus_mode), .instruction_byte_one(ib1), .instruction_byte_two(ib2),
    .instruction_byte_three(ib3), .rd_status(rd_status), .rd_offset(rd_offset), .standby_pin_in(stb_wire),
    .low_headroom(lo_hr), .supply_above_mute(above_mute), .supply_below_reset(below_rst), .supply_low_bat(low_bat),
    .supply_over(over), .temp_warn_lo(twl), .temp_warn_hi(twh), .temp_off(toff), .ripple_reject_empty(rre),
    .clip_det(clip), .short_det(shrt), .missing_det(miss), .offset_in_window(win), .dc_line_driver(dc_ld),
    .dc_open(dc_op), .ac_peak(peak), .fast_mute(fmute), .discharge_nodes(dis), .amp_enable(amp_en),
    .outputs_hiz(hiz), .gain_reduce(gred), .dc_detect_run(dcrun), .ac_detect_run(acrun), .warn_level_sel(wsel),
    .clip_level(clvl), .fault_indicator_pin_out(), .fault_indicator_pin_oe_n(fo_oe_n), .standby_pin_out(),
    .standby_pin_oe_n(so_oe_n), .status_byte_two(sb2), .channel_status_byte(csb));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (dis) dis_seen <= 1'b1;
  task automatic cb(input string n, input logic e, input logic g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic cf(input string n, input logic [1:0] e, input logic [1:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic final_report;
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic settle;
    repeat (12) @(negedge clk_sys);
  endtask
  // peak detector pulses at the 160 ns link rate
  task automatic pulse_peak(input int n);
    repeat (n) begin
      peak[0] = 1'b1;
      repeat (16) @(negedge clk_sys);
      peak[0] = 1'b0;
      repeat (16) @(negedge clk_sys);
    end
  endtask
  // s = {low bat, over, warn lo, warn hi, clip[3:0], short[3:0], missing[3:0]}
  function automatic logic exp_fault(input logic bm, input apd_byte_t b1, input apd_byte_t b2, input logic w,
    input logic [15:0] s);
    logic tmp, cl;
    tmp = (bm && w) ? s[12] : s[13];
    cl = bm ? ((b2[7:6] != 2'h3) && |(s[11:8] & ~{b1[4], b1[6], b1[3], b1[5]})) : |s[11:8];
    return s[15] | s[14] | (tmp & !(bm & b2[5])) | (|s[7:0] & !(bm & b2[4])) | cl;
  endfunction
  task automatic fault_round(input logic bm, input int n);
    logic [15:0] s;
    apd_byte_t b1, b2, b3;
    repeat (n) begin
      s = 16'($random(seed) & $random(seed) & $random(seed));
      b1 = bm ? 8'h03 : 8'($random(seed));
      b2 = 8'($random(seed)) & (bm ? 8'hf0 : 8'hff);
      b3 = 8'($random(seed));
      u_host.write_ib(b1, b2, b3);
      {low_bat, over, twl, twh, clip, shrt, miss} = s;
      {win, peak, dc_ld, dc_op} = 16'($random(seed));
      settle;
      cb("fault_pin", !exp_fault(bm, b1, b2, b3[4], s), fo_oe_n);
      if (s[14]) cb("hiz", 1'b1, hiz);
      cf("clip_level", bm ? b2[7:6] : 2'h0, clvl);
      {low_bat, over, twl, twh, clip, shrt, miss} = '0;
      {win, peak, dc_ld, dc_op} = '0;
      settle;
      cb("fault_release", 1'b1, fo_oe_n);
    end
  endtask
  initial begin
    #400000;
    err_total++;
    final_report;
  end
  initial begin
    seed = 69398;
    err_total = 0;
    checks = 0;
    dis_seen = 1'b0;
    {rst_n, lo_hr, below_rst, low_bat, over, twl, twh, toff, clip, shrt, miss, win, dc_ld, dc_op, peak} = '0;
    {bus_mode, stb_drive, above_mute, rre} = 4'hf;
    repeat (2) @(negedge clk_sys);
    rst_n = 1'b1;
    settle;
    cb("por_flag", 1'b1, sb2[7]);
    cb("fault_por", 1'b0, fo_oe_n);
    cb("stb_por", 1'b1, so_oe_n);
    u_host.write_ib(8'h03, 8'h00, 8'h00);
    dc_ld = 4'b0110;
    dc_op = 4'b0100;
    settle;
    cb("por_clear", 1'b0, sb2[7]);
    cb("fault_start", 1'b1, fo_oe_n);
    cb("dc_run", 1'b1, dcrun);
    rre = 1'b0;
    settle;
    cb("unmute", 1'b0, fmute);
    for (c = 0; c < 4; c++) cf("dc_load", {dc_ld[c] | dc_op[c], dc_op[c]}, csb[c][5:4]);
    {dc_ld, dc_op} = '0;
    u_host.write_ib(8'h07, 8'h00, 8'h00);
    settle;
    cb("ac_run", 1'b1, acrun);
    cb("dc_idle", 1'b0, dcrun);
    cb("ac_none", 1'b0, csb[0][4]);
    pulse_peak(2);
    cb("ac_two", 1'b0, csb[0][4]);
    pulse_peak(1);
    cb("ac_three", 1'b1, csb[0][4]);
    cb("ac_shown", 1'b0, csb[2][4]);
    u_host.write_ib(8'h03, 8'h00, 8'h00);
    settle;
    cb("dc_back_open", 1'b1, csb[2][4]);
    cb("dc_back_norm", 1'b0, csb[0][4]);
    u_host.read_pulse(1'b1);
    settle;
    for (c = 0; c < 4; c++) cb("offset_set", 1'b1, csb[c][2]);
    win = 4'h1;
    settle;
    win = 4'h0;
    settle;
    u_host.read_pulse(1'b1);
    settle;
    cb("offset_clr", 1'b0, csb[0][2]);
    cb("offset_keep", 1'b1, csb[1][2]);
    twl = 1'b1;
    settle;
    cb("gain_red", 1'b1, gred);
    twl = 1'b0;
    settle;
    cb("warn_held", 1'b1, sb2[`APD_DB2_WARN]);
    u_host.read_pulse(1'b0);
    settle;
    cb("warn_read", 1'b0, sb2[`APD_DB2_WARN]);
    fault_round(1'b1, 24);
    toff = 1'b1;
    settle;
    cb("toff_off", 1'b0, amp_en);
    toff = 1'b0;
    lo_hr = 1'b1;
    settle;
    cb("hr_mute", 1'b1, fmute);
    {rre, lo_hr, above_mute} = 3'h4;
    settle;
    settle;
    cb("hr_discharge", 1'b1, dis_seen);
    cb("low_supply_off", 1'b0, amp_en);
    above_mute = 1'b1;
    stb_drive = 1'b0;
    settle;
    cb("stb_mute", 1'b1, fmute);
    stb_drive = 1'b1;
    u_host.write_ib(8'h00, 8'h00, 8'h00);
    u_host.write_ib(8'h21, 8'h00, 8'h00);
    clip = 4'h1;
    settle;
    cb("stb_clip", 1'b0, so_oe_n);
    clip = 4'h0;
    below_rst = 1'b1;
    settle;
    below_rst = 1'b0;
    settle;
    cb("por_again", 1'b1, sb2[7]);
    bus_mode = 1'b0;
    settle;
    fault_round(1'b0, 16);
    final_report;
  end
endmodule // amp_protection_diagnostics_tb
bind apd_protect apd_protect_checker #(.DEBOUNCE_CYC(DEBOUNCE_CYC), .FMUTE_CYC(FMUTE_CYC), .AC_TRIGS(AC_TRIGS)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .bus_mode(bus_mode), .instruction_byte_one(instruction_byte_one),
  .instruction_byte_two(instruction_byte_two), .instruction_byte_three(instruction_byte_three),
  .standby_pin_in(standby_pin_in), .supply_below_reset(supply_below_reset), .supply_low_bat(supply_low_bat),
  .supply_over(supply_over), .temp_warn_lo(temp_warn_lo), .temp_warn_hi(temp_warn_hi), .temp_off(temp_off),
  .clip_det(clip_det), .short_det(short_det), .missing_det(missing_det), .offset_in_window(offset_in_window),
  .ac_peak(ac_peak), .fast_mute(fast_mute), .amp_enable(amp_enable), .outputs_hiz(outputs_hiz),
  .dc_detect_run(dc_detect_run), .ac_detect_run(ac_detect_run), .warn_level_sel(warn_level_sel),
  .clip_level(clip_level), .fault_indicator_pin_oe_n(fault_indicator_pin_oe_n), .status_byte_two(status_byte_two),
  .channel_status_byte(channel_status_byte));
